//--- shared/exec_consts.svh
/*
  Constants for the branch, skip, load and store execution unit:
  opcode classes, instruction field positions, status flag positions,
  pointer and mode codes, register-port offsets and reset values.
  Assumes it is included by bare name, once or more.
*/
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

// ----------------------------------------------------------------
// opcode classes in instr[15:12]
// ----------------------------------------------------------------
`define OP_SKRC 4'h0
`define OP_SKRS 4'h1
`define OP_SKIC 4'h2
`define OP_SKIS 4'h3
`define OP_BFS 4'h4
`define OP_BFC 4'h5
`define OP_BGE 4'h6
`define OP_BLT 4'h7
`define OP_LDI 4'h8
`define OP_STI 4'h9
`define OP_LDD 4'hA
`define OP_LDS 4'hB

// ----------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------
`define F_OP 15:12
`define F_BIT 2:0
`define F_FLAG 2:0
`define F_K 9:3
`define F_K_MSB 9
`define F_PTR 11:10
`define F_MODE 9:8
`define F_DPTR 11
`define F_Q 10:5
`define F_RD 4:0

// ----------------------------------------------------------------
// status flag positions
// ----------------------------------------------------------------
`define FL_C 3'h0
`define FL_Z 3'h1
`define FL_N 3'h2
`define FL_V 3'h3
`define FL_S 3'h4
`define FL_H 3'h5
`define FL_T 3'h6
`define FL_I 3'h7

// ----------------------------------------------------------------
// pointer and addressing mode codes
// ----------------------------------------------------------------
`define PTR_X 2'h0
`define PTR_Y 2'h1
`define MD_INC 2'h1
`define MD_DEC 2'h2

// ----------------------------------------------------------------
// register port offsets, reset values, steps and counts
// ----------------------------------------------------------------
`define RA_X 3'h0
`define RA_Y 3'h1
`define RA_Z 3'h2
`define RA_PC 3'h3
`define RA_STAT 3'h4
`define PC_RST 16'h0000
`define PTR_RST 16'h0000
`define STEP1 16'h0001
`define STEP2 16'h0002
`define STEP3 16'h0003
`define CNT_ZERO 2'h0
`define CNT_ONE 2'h1

`endif

//--- shared/exec_pkg.sv
/*
  Types for the branch, skip, load and store execution unit:
  state enum, memory request, register write-back and the full
  registered state of the unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package exec_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } exec_state_t;

  // data memory request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } mem_req_t;

  // general register write-back
  typedef struct packed {
    logic we;
    logic [4:0] idx;
    logic [7:0] data;
  } wb_t;

  // everything the unit remembers
  typedef struct packed {
    exec_state_t st;
    logic [1:0] cnt;
    logic [15:0] pc;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    mem_req_t mem;
    wb_t wb;
    logic ld_pend;
    logic [4:0] ld_idx;
    logic ready;
    logic done;
    logic [15:0] rdata;
  } core_state_t;

endpackage

//--- hw/exec_unit.sv
/*
  Execution unit for bit skips, flag branches and pointer based
  loads and stores of an 8-bit core, with its program counter and
  the three 16-bit data pointers.
  Assumes: all inputs come from logic on clk; the register file
  supplies the selected register value beside issue; data memory
  returns read data in the cycle after the read strobe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "exec_consts.svh"

module exec_unit
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic issue,
  input wire logic [15:0] instr,
  input wire logic [15:0] instr2,
  input wire logic next_two_word,
  input wire logic [7:0] status_register,
  input wire logic [7:0] reg_val,
  input wire logic [7:0] io_val,
  input wire logic [7:0] mem_rdata,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic ready,
  output logic done,
  output logic [15:0] pc,
  output mem_req_t mem,
  output wb_t wb
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // pick a pointer; code 3 falls back to z
  function automatic logic [15:0] ptr_of(
    input logic [1:0] sel,
    input logic [15:0] px,
    input logic [15:0] py,
    input logic [15:0] pz
  );
    logic [15:0] r;
    r = pz;
    if (sel == `PTR_X) begin
      r = px;
    end else if (sel == `PTR_Y) begin
      r = py;
    end
    return r;
  endfunction

  function automatic logic [15:0] rel_target(
    input logic [15:0] base,
    input logic [6:0] k
  );
    logic [15:0] ext;
    // sign bit copied up; the sum wraps at 64K like the pc
    ext = {{9{k[6]}}, k};
    return base + ext + `STEP1;
  endfunction

  // status bit chosen by the operand field
  function automatic logic flag_bit(
    input logic [7:0] s,
    input logic [2:0] f
  );
    logic r;
    r = 1'b0;
    unique case (f)
      `FL_Z: r = s[`FL_Z];
      `FL_C: r = s[`FL_C];
      `FL_N: r = s[`FL_N];
      `FL_V: r = s[`FL_V];
      // sign flag, reachable by the generic forms only
      `FL_S: r = s[`FL_S];
      `FL_H: r = s[`FL_H];
      `FL_T: r = s[`FL_T];
      `FL_I: r = s[`FL_I];
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // ready is high in reset, so an issue may come at the first edge after release
  localparam core_state_t RST_STATE = '{
    st: ST_IDLE,
    cnt: `CNT_ZERO,
    pc: `PC_RST,
    x: `PTR_RST,
    y: `PTR_RST,
    z: `PTR_RST,
    mem: '0,
    wb: '0,
    ld_pend: 1'b0,
    ld_idx: 5'h00,
    ready: 1'b1,
    done: 1'b0,
    rdata: 16'h0000
  };

  core_state_t q_ff;
  core_state_t nxt_q;

  // decode scratch
  // p: selected pointer, a: access address, np: pointer after access
  logic [3:0] op;
  logic hit;
  logic bitv;
  logic [15:0] p;
  logic [15:0] a;
  logic [15:0] np;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    op = instr[`F_OP];
    hit = 1'b0;
    bitv = 1'b0;
    // pointer picked up front; only loads and stores look at it
    p = ptr_of(instr[`F_PTR], q_ff.x, q_ff.y, q_ff.z);
    a = p;
    np = p;
    // strobes are single cycle
    // every pulse is cleared by default and raised only where needed
    nxt_q.mem.we = 1'b0;
    nxt_q.mem.re = 1'b0;
    nxt_q.wb.we = 1'b0;
    nxt_q.done = 1'b0;
    nxt_q.rdata = 16'h0000;

    // read data lands one cycle after the strobe, so write it
    // back independently of the sequencer
    // a load result may land while the next instruction already runs
    nxt_q.ld_pend = q_ff.mem.re;
    if (q_ff.ld_pend) begin
      nxt_q.wb.we = 1'b1;
      nxt_q.wb.idx = q_ff.ld_idx;
      nxt_q.wb.data = mem_rdata;
    end

    unique case (q_ff.st)
      ST_IDLE: begin
        // issue outside idle is not looked at
        if (issue) begin
          unique case (op)
            `OP_SKRC, `OP_SKRS, `OP_SKIC, `OP_SKIS: begin
              if (op == `OP_SKRC) begin
                hit = !reg_val[instr[`F_BIT]];
              end
              if (op == `OP_SKRS) begin
                hit = reg_val[instr[`F_BIT]];
              end
              if (op == `OP_SKIC) begin
                hit = !io_val[instr[`F_BIT]];
              end
              if (op == `OP_SKIS) begin
                hit = io_val[instr[`F_BIT]];
              end
              if (hit) begin
                // skip length by next size
                // the caller says how long the next word is; it is not fetched here
                nxt_q.st = ST_WAIT;
                nxt_q.ready = 1'b0;
                if (next_two_word) begin
                  nxt_q.pc = q_ff.pc + `STEP3;
                  nxt_q.cnt = `CNT_ONE;
                end else begin
                  nxt_q.pc = q_ff.pc + `STEP2;
                  nxt_q.cnt = `CNT_ZERO;
                end
              end else begin
                nxt_q.pc = q_ff.pc + `STEP1;
                nxt_q.done = 1'b1;
              end
            end
            `OP_BFS, `OP_BFC, `OP_BGE, `OP_BLT: begin
              // the signed forms test N xor V directly rather than a flag picked by index
              bitv = flag_bit(status_register, instr[`F_FLAG]);
              if (op == `OP_BFS) begin
                hit = bitv;
              end
              if (op == `OP_BFC) begin
                hit = !bitv;
              end
              if (op == `OP_BGE) begin
                hit = !(status_register[`FL_N] ^ status_register[`FL_V]);
              end
              if (op == `OP_BLT) begin
                hit = status_register[`FL_N] ^ status_register[`FL_V];
              end
              // taken costs two, else one
              // one adder for every branch form keeps the taken path uniform
              if (hit) begin
                nxt_q.pc = rel_target(q_ff.pc, instr[`F_K]);
                nxt_q.st = ST_WAIT;
                nxt_q.ready = 1'b0;
                nxt_q.cnt = `CNT_ZERO;
              end else begin
                nxt_q.pc = q_ff.pc + `STEP1;
                nxt_q.done = 1'b1;
              end
            end
            `OP_LDI, `OP_STI: begin
              if (instr[`F_MODE] == `MD_DEC) begin
                a = p - `STEP1;
                np = a;
              end
              if (instr[`F_MODE] == `MD_INC) begin
                np = p + `STEP1;
              end
              // plain mode writes the pointer back unchanged; code 3 acts as z
              if (instr[`F_PTR] == `PTR_X) begin
                nxt_q.x = np;
              end else if (instr[`F_PTR] == `PTR_Y) begin
                nxt_q.y = np;
              end else begin
                nxt_q.z = np;
              end
              nxt_q.mem.addr = a;
              if (op == `OP_STI) begin
                nxt_q.mem.we = 1'b1;
                nxt_q.mem.wdata = reg_val;
              end else begin
                nxt_q.mem.re = 1'b1;
                nxt_q.ld_idx = instr[`F_RD];
              end
              nxt_q.pc = q_ff.pc + `STEP1;
              nxt_q.st = ST_WAIT;
              nxt_q.ready = 1'b0;
              nxt_q.cnt = `CNT_ZERO;
            end
            `OP_LDD: begin
              // base plus unsigned displacement
              // six-bit displacement, forward only; the pointer is left alone
              if (instr[`F_DPTR]) begin
                a = q_ff.z + {10'h000, instr[`F_Q]};
              end else begin
                a = q_ff.y + {10'h000, instr[`F_Q]};
              end
              nxt_q.mem.addr = a;
              nxt_q.mem.re = 1'b1;
              nxt_q.ld_idx = instr[`F_RD];
              nxt_q.pc = q_ff.pc + `STEP1;
              nxt_q.st = ST_WAIT;
              nxt_q.ready = 1'b0;
              nxt_q.cnt = `CNT_ZERO;
            end
            `OP_LDS: begin
              // address from second word
              // the second word carries all sixteen address bits
              nxt_q.mem.addr = instr2;
              nxt_q.mem.re = 1'b1;
              nxt_q.ld_idx = instr[`F_RD];
              nxt_q.pc = q_ff.pc + `STEP2;
              nxt_q.st = ST_WAIT;
              nxt_q.ready = 1'b0;
              nxt_q.cnt = `CNT_ZERO;
            end
            default: begin
              // classes handled elsewhere pass as one cycle no-ops
              // they still move the pc, so a stream of them walks forward
              nxt_q.pc = q_ff.pc + `STEP1;
              nxt_q.done = 1'b1;
            end
          endcase
        end
      end
      ST_WAIT: begin
        // count off the extra cycles of the instruction
        // ready stays low, so an issue here is dropped rather than queued
        if (q_ff.cnt == `CNT_ZERO) begin
          nxt_q.st = ST_IDLE;
          nxt_q.ready = 1'b1;
          nxt_q.done = 1'b1;
        end else begin
          nxt_q.cnt = q_ff.cnt - `CNT_ONE;
        end
      end
    endcase

    // software writes come last so they win over execution
    // a pc write during a wait redirects the flow but does not end the wait
    if (reg_wr) begin
      unique case (reg_addr)
        `RA_X: nxt_q.x = reg_wdata;
        `RA_Y: nxt_q.y = reg_wdata;
        `RA_Z: nxt_q.z = reg_wdata;
        `RA_PC: nxt_q.pc = reg_wdata;
        default: ;
      endcase
    end

    // register reads answer in the next cycle, unmapped read zero
    // status holds only the ready bit; the rest reads zero for growth
    if (reg_rd) begin
      unique case (reg_addr)
        `RA_X: nxt_q.rdata = q_ff.x;
        `RA_Y: nxt_q.rdata = q_ff.y;
        `RA_Z: nxt_q.rdata = q_ff.z;
        `RA_PC: nxt_q.rdata = q_ff.pc;
        `RA_STAT: nxt_q.rdata = {15'h0000, q_ff.ready};
        default: nxt_q.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // asynchronous clear back to the constant reset image
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_ff <= RST_STATE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // outputs straight from the state register
  // no gates after the flops, so the pins see clean registered values
  assign reg_rdata = q_ff.rdata;
  assign ready = q_ff.ready;
  assign done = q_ff.done;
  assign pc = q_ff.pc;
  assign mem = q_ff.mem;
  assign wb = q_ff.wb;

endmodule
`default_nettype wire

//--- dv/exec_unit_assertions.sv
/*
  Checker for exec_unit: timing and results of skips, branches, loads, stores.
  Assumes it is bound to exec_unit and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module exec_unit_assertions import exec_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic issue,
  input wire logic [15:0] instr,
  input wire logic [15:0] instr2,
  input wire logic next_two_word,
  input wire logic [7:0] status_register,
  input wire logic [7:0] reg_val,
  input wire logic [7:0] io_val,
  input wire logic [7:0] mem_rdata,
  input wire logic ready,
  input wire logic done,
  input wire logic [15:0] pc,
  input wire mem_req_t mem,
  input wire wb_t wb
);
  // --------------------------------------------------------------
  // accepted issue and decoded fields
  // --------------------------------------------------------------
  wire logic tk = issue && ready;
  wire logic [3:0] op = instr[15:12];
  wire logic [15:0] boff = {{9{instr[9]}}, instr[9:3]} + 16'h0001;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  a_load_seq: assert property (tk && op == 4'h8
    |=> mem.re && !ready ##1 done && ready) else $error("load sequence wrong");
  a_store_data: assert property (tk && op == 4'h9
    |=> mem.we && mem.wdata == $past(reg_val) ##1 done) else $error("store data wrong");
  a_branch_taken: assert property (tk && op == 4'h4 && status_register[instr[2:0]]
    |=> pc == $past(pc) + $past(boff) ##1 done) else $error("taken branch wrong");
  a_branch_fall: assert property (tk && op == 4'h5 && status_register[instr[2:0]]
    |=> done && pc == $past(pc) + 16'h0001) else $error("untaken branch wrong");
  a_signed_lt: assert property (tk && op == 4'h7 && (status_register[2] ^ status_register[3])
    |=> !done ##1 done) else $error("signed lt timing wrong");
  a_signed_ge: assert property (tk && op == 4'h6 && (status_register[2] ^ status_register[3])
    |=> done && pc == $past(pc) + 16'h0001) else $error("signed ge not fall through");
  a_skip_long: assert property (tk && op == 4'h0 && !reg_val[instr[2:0]]
    && next_two_word |=> pc == $past(pc) + 16'h0003 ##2 done) else $error("long skip wrong");
  a_io_skip: assert property (tk && op == 4'h3 && io_val[instr[2:0]] && !next_two_word
    |=> pc == $past(pc) + 16'h0002 ##1 done) else $error("io skip wrong");
  a_direct_addr: assert property (tk && op == 4'hB
    |=> mem.re && mem.addr == $past(instr2) && pc == $past(pc) + 16'h0002)
    else $error("direct load address wrong");
  a_disp_wb: assert property (tk && op == 4'hA
    |=> ##2 wb.we && wb.data == $past(mem_rdata)) else $error("displaced load data wrong");
endmodule
bind exec_unit exec_unit_assertions chk_i (.clk(clk), .reset_n(reset_n), .issue(issue),
  .instr(instr), .instr2(instr2), .next_two_word(next_two_word), .status_register(status_register),
  .reg_val(reg_val), .io_val(io_val), .mem_rdata(mem_rdata), .ready(ready),
  .done(done), .pc(pc), .mem(mem), .wb(wb));
`default_nettype wire

//--- dv/data_mem_model.sv
/*
  Data memory partner for exec_unit: 256 bytes, read data in the cycle
  after the read strobe. Assumes one clock and addresses below 256.
*/
`timescale 1ns/10ps
`default_nettype none
module data_mem_model import exec_pkg::*; (
  input wire logic clk,
  input wire mem_req_t mem,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:255];
  // known contents so every load has a computable answer
  initial begin
    for (int i = 0; i < 256; i++) begin
      ram[i] = 8'(i * 7 + 3);
    end
  end
  // data only in the cycle after the strobe; flips otherwise
  // so a late sample never sees a stale but plausible byte
  always @(posedge clk) begin
    if (mem.we) begin
      ram[mem.addr[7:0]] <= mem.wdata;
    end
    mem_rdata <= mem.re ? ram[mem.addr[7:0]] : ~mem_rdata;
  end
endmodule
`default_nettype wire

//--- dv/exec_unit_tb.sv
/*
  Bench for exec_unit: issue and register tasks with expected results.
  Assumes exec_unit, data_mem_model and the checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module exec_unit_tb import exec_pkg::*; ;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic issue = 1'h0;
  logic next_two_word = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [15:0] instr = 16'h0;
  logic [15:0] instr2 = 16'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic [7:0] status_register = 8'h0;
  logic [7:0] reg_val = 8'h0;
  logic [7:0] io_val = 8'h0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] mem_rdata;
  logic [15:0] reg_rdata;
  logic [15:0] pc;
  logic ready;
  logic done;
  mem_req_t mem;
  wb_t wb;
  int err_total = 0;
  int check_count = 0;
  logic [15:0] off;
  logic [7:0] fl;
  logic [6:0] kk;
  logic [2:0] b;
  logic x;

  always #12.5 clk = ~clk;

  exec_unit uut (.clk(clk), .reset_n(reset_n), .issue(issue), .instr(instr),
    .instr2(instr2), .next_two_word(next_two_word), .status_register(status_register), .reg_val(reg_val),
    .io_val(io_val), .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ready(ready),
    .done(done), .pc(pc), .mem(mem), .wb(wb));
  data_mem_model m (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk(reg_rdata, e);
  endtask
  // c packs next_two_word, status flags, register value, io value
  task run(input logic [15:0] i, input logic [15:0] i2, input logic [24:0] c,
    input int cyc, input logic [15:0] dpc);
    logic [15:0] p0;
    int n;
    @(posedge clk);
    p0 = pc;
    issue <= 1'h1;
    instr <= i;
    instr2 <= i2;
    {next_two_word, status_register, reg_val, io_val} <= c;
    @(posedge clk);
    issue <= 1'h0;
    // done of a one-cycle op stands right after the taking edge
    n = 1;
    #1;
    // bounded wait for the finishing pulse
    while (done !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
      #1;
    end
    chk(16'(n), 16'(cyc));
    chk(pc, p0 + dpc);
  endtask
  // write-back lands one cycle after done
  task ld(input logic [15:0] i, input logic [15:0] i2, input logic [15:0] dpc,
    input logic [15:0] a);
    run(i, i2, 25'h0, 2, dpc);
    @(posedge clk);
    #1;
    chk({wb.we, 2'h0, wb.idx, wb.data}, {1'h1, 2'h0, i[4:0], 8'(a * 7 + 3)});
  endtask

  // ------------------------------------------------------------
  // watchdog, far longer than the few hundred cycles needed
  // ------------------------------------------------------------
  initial begin
    #100000;
    err_total++;
    stop_test;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    rd(3'h3, 16'h0000);
    rd(3'h4, 16'h0001);
    wr(3'h5, 16'hFFFF);
    rd(3'h5, 16'h0000);
    $display("test reset done");
    // every status bit, both polarities, extreme offsets
    for (int s = 0; s < 8; s++) begin
      for (int p = 0; p < 2; p++) begin
        kk = s[0] ? 7'h40 : 7'h3F;
        off = {{9{kk[6]}}, kk} + 16'h0001;
        fl = p[0] ? ~(8'h01 << s) : 8'h01 << s;
        run({4'h4, 2'h0, kk, s[2:0]}, '0, {1'h0, fl, 16'h0}, p ? 1 : 2, p ? 16'h1 : off);
        run({4'h5, 2'h0, kk, s[2:0]}, '0, {1'h0, fl, 16'h0}, p ? 2 : 1, p ? off : 16'h1);
      end
    end
    // signed tests over all N and V pairs
    for (int v = 0; v < 4; v++) begin
      fl = 8'(v << 2);
      x = v[0] ^ v[1];
      run({4'h6, 12'h028}, '0, {1'h0, fl, 16'h0}, x ? 1 : 2, x ? 16'h1 : 16'h6);
      run({4'h7, 12'h028}, '0, {1'h0, fl, 16'h0}, x ? 2 : 1, x ? 16'h6 : 16'h1);
    end
    $display("test branches done");
    // register and io skips over one and two words
    for (int o = 0; o < 4; o++) begin
      for (int v = 0; v < 2; v++) begin
        for (int t = 0; t < 2; t++) begin
          b = 3'(o + v + t + 3);
          fl = v[0] ? 8'h01 << b : ~(8'h01 << b);
          x = o[0] == v[0];
          run({4'(o), 9'h0, b}, '0, {t[0], 8'h0, o < 2 ? fl : ~fl, o < 2 ? ~fl : fl},
            x ? 2 + t : 1, x ? 16'(2 + t) : 16'h1);
        end
      end
    end
    $display("test skips done");
    wr(3'h0, 16'h0010);
    wr(3'h1, 16'h0020);
    wr(3'h2, 16'h0030);
    ld({4'h8, 2'h0, 2'h1, 8'h05}, '0, 16'h1, 16'h0010);
    rd(3'h0, 16'h0011);
    ld({4'h8, 2'h1, 2'h2, 8'h06}, '0, 16'h1, 16'h001F);
    rd(3'h1, 16'h001F);
    ld({4'h8, 2'h1, 2'h0, 8'h09}, '0, 16'h1, 16'h001F);
    rd(3'h1, 16'h001F);
    ld({4'hA, 1'h1, 6'h3F, 5'h07}, '0, 16'h1, 16'h006F);
    rd(3'h2, 16'h0030);
    ld({4'hB, 12'h008}, 16'h0042, 16'h2, 16'h0042);
    run({4'h9, 2'h0, 2'h1, 8'h0}, '0, {9'h0, 8'hC3, 8'h0}, 2, 16'h1);
    chk(m.ram[8'h11], 16'h00C3);
    rd(3'h0, 16'h0012);
    run({4'h9, 2'h2, 2'h2, 8'h0}, '0, {9'h0, 8'h3C, 8'h0}, 2, 16'h1);
    chk(m.ram[8'h2F], 16'h003C);
    rd(3'h2, 16'h002F);
    ld({4'h8, 2'h3, 2'h2, 8'h0A}, '0, 16'h1, 16'h002E);
    rd(3'h2, 16'h002E);
    $display("test memory done");
    // mid-run reset must bring the z pointer and pc back to zero
    @(posedge clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    rd(3'h2, 16'h0000);
    rd(3'h3, 16'h0000);
    rd(3'h4, 16'h0001);
    $display("test second reset done");
    stop_test;
  end
endmodule
`default_nettype wire
